/* File: common/mmap_pkg.sv */
// =====================================================
// memory map constants and carriers
package mmap_pkg;

  // =====================================================
  // widths and depths
  localparam int BYTE_W = 8; // data byte width
  localparam int CODE_AW = 16; // 64 kB program space
  localparam int IRAM_DEPTH = 256; // internal data ram
  localparam int ONCHIP_EXTERNAL_RAM_DEPTH = 256; // on-chip external ram
  localparam int RAM_AW = 8; // ram address width

  // =====================================================
  // program space
  localparam logic [15:0] FLASH_BASE = 16'h0000; // flash start
  localparam logic [15:0] FLASH_TOP_8K = 16'h1FFF; // 8 kB end
  localparam logic [15:0] FLASH_TOP_4K = 16'h0FFF; // 4 kB end
  localparam logic [15:0] FLASH_TOP_2K = 16'h07FF; // 2 kB end
  localparam logic [7:0] FLASH_ERASED = 8'hFF; // reserved reads

  // flash size variant strap
  typedef enum logic [1:0] {
    SIZE_8K,
    SIZE_4K,
    SIZE_2K
  } flash_size_t;

  // =====================================================
  // data space
  localparam logic [7:0] LOWER_TOP = 8'h7F; // end of lower half
  localparam logic [7:0] BIT_BASE = 8'h20; // bit area start
  localparam logic [7:0] SFR_SP = 8'h81; // stack_pointer
  localparam logic [7:0] SFR_ACC = 8'hE0; // primary_arith_reg
  localparam logic [7:0] SFR_B = 8'hF0; // second_arith_reg
  localparam logic [7:0] SP_RESET = 8'h07; // stack_pointer reset
  localparam logic [7:0] ACC_RESET = 8'h00; // primary reset
  localparam logic [7:0] B_RESET = 8'h00; // secondary reset
  localparam logic [7:0] READ_NONE = 8'h00; // unmapped read
  localparam logic [7:0] ONE_BYTE = 8'h01; // pointer step
  localparam logic [7:0] BIT_ONE = 8'h01; // single bit mask
  localparam int BANK_LO_POS = 3; // bank_select_low
  localparam int BANK_HI_POS = 4; // bank_select_high

  // addressing mode of a data access
  typedef enum logic [1:0] {
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_BANKREG,
    MODE_BIT
  } access_mode_t;

  // storage that a data access lands in
  typedef enum logic [1:0] {
    TGT_NONE,
    TGT_IRAM,
    TGT_SFR,
    TGT_ONCHIP_EXTERNAL_RAM
  } target_t;

  // =====================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic write;
    access_mode_t mode;
    logic [7:0] addr;
    logic [7:0] wdata;
  } data_req_t;

  typedef struct packed {
    logic push;
    logic pop;
    logic [7:0] wdata;
  } stack_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ext_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } code_req_t;

  typedef struct packed {
    logic rd;
    logic [15:0] raddr;
    logic wr;
    logic erase;
    logic [15:0] waddr;
    logic [7:0] wdata;
  } flash_cmd_t;

endpackage : mmap_pkg

/* File: verilog/ram_block.sv */
`timescale 1ns/1ps
// =====================================================
// byte ram with bit-masked write and registered read
module ram_block #(
  parameter int DEPTH = mmap_pkg::IRAM_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [mmap_pkg::RAM_AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_wmask,
  output logic [7:0] o_rdata
);

  logic [7:0] mem [DEPTH]; // storage array
  logic [7:0] rdata_reg; // read latch
  logic [7:0] rdata_next; // next read value

  // write merges only the masked bits
  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_addr] <= (mem[i_addr] & ~i_wmask) | (i_wdata & i_wmask);
    end
  end

  // read value for the next edge, old data on collision
  always_comb begin
    rdata_next = rdata_reg;
    if (i_re) begin
      rdata_next = mem[i_addr];
    end
  end

  // read latch
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_reg <= mmap_pkg::READ_NONE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;

endmodule : ram_block

/* File: verilog/flash_decode.sv */
`timescale 1ns/1ps
// =====================================================
// program address decode against the flash size
module flash_decode (
  input wire mmap_pkg::flash_size_t i_size,
  input wire logic [15:0] i_addr,
  output logic o_in_flash,
  output logic o_is_lock,
  output logic o_reserved
);

  logic [15:0] top; // last populated address

  // last flash byte for a size variant
  function automatic logic [15:0] top_of(mmap_pkg::flash_size_t s);
    case (s)
      mmap_pkg::SIZE_8K: top_of = mmap_pkg::FLASH_TOP_8K;
      mmap_pkg::SIZE_4K: top_of = mmap_pkg::FLASH_TOP_4K;
      default: top_of = mmap_pkg::FLASH_TOP_2K;
    endcase
  endfunction : top_of

  // classify the address
  always_comb begin
    top = top_of(i_size);
    o_in_flash = (i_addr >= mmap_pkg::FLASH_BASE) && (i_addr <= top);
    o_is_lock = (i_addr == top);
    o_reserved = (i_addr > top);
  end

endmodule : flash_decode

/* File: verilog/mcu_memory_map_decode.sv */
`timescale 1ns/1ps
module mcu_memory_map_decode (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire mmap_pkg::flash_size_t i_flash_size,
  input wire logic [7:0] i_program_status_word,
  input wire logic i_flash_wr_redirect,
  input wire logic i_flash_erase_sel,
  input wire mmap_pkg::data_req_t i_data_req,
  input wire mmap_pkg::stack_req_t i_stack_req,
  input wire mmap_pkg::ext_req_t i_ext_req,
  input wire mmap_pkg::code_req_t i_code_req,
  input wire logic [7:0] i_flash_rdata,
  output mmap_pkg::flash_cmd_t o_flash_cmd,
  output mmap_pkg::target_t o_data_target,
  output logic o_sfr_other_sel,
  output logic o_rdata_valid,
  output logic [7:0] o_rdata,
  output logic o_rbit,
  output logic o_xdata_valid,
  output logic [7:0] o_xdata,
  output logic o_ext_refused,
  output logic o_code_valid,
  output logic [7:0] o_code_data,
  output logic o_code_lock,
  output logic o_code_reserved,
  output logic [7:0] o_stack_pointer,
  output logic [7:0] o_primary_arith_reg,
  output logic [7:0] o_second_arith_reg
);

  // =====================================================
  // declarations
  logic [1:0] bank; // active register bank
  logic [7:0] eff_addr; // effective data address
  logic [2:0] bit_pos; // bit within byte
  logic [7:0] wmask; // write bit mask
  logic [7:0] wbyte; // write data lanes
  mmap_pkg::target_t tgt; // decoded data target
  logic data_go, stk_go; // data access and stack op taken
  logic iram_we, iram_re; // internal ram strobes
  logic [7:0] iram_addr; // internal ram address
  logic [7:0] iram_wdata; // internal ram data
  logic [7:0] iram_wmask; // internal ram mask
  logic [7:0] iram_q; // internal ram read data
  logic onchip_external_ram_we, onchip_external_ram_re; // external ram strobes
  logic [7:0] onchip_external_ram_q; // external ram read data
  logic ext_to_flash; // ext write redirected
  logic ext_in_flash, ext_is_lock, ext_reserved; // ext address class
  logic code_in_flash, code_is_lock, code_reserved; // code address class
  logic sfr_we, sfr_re; // special register strobes
  logic [7:0] sfr_rd; // special register read mux
  logic [7:0] sp_reg, sp_next; // stack_pointer
  logic [7:0] acc_reg, acc_next; // primary_arith_reg
  logic [7:0] b_reg, b_next; // second_arith_reg
  mmap_pkg::target_t rd_tgt_reg, rd_tgt_next; // target of pending read
  logic [2:0] rd_bit_reg, rd_bit_next; // bit of pending read
  logic [7:0] sfr_q_reg, sfr_q_next; // latched register read
  logic rd_valid_reg, rd_valid_next; // data read answer
  logic x_valid_reg, x_valid_next; // ext read answer
  logic code_valid_reg, code_valid_next; // code read answer
  logic [7:0] code_data_reg, code_data_next; // code read data
  logic code_lock_reg, code_lock_next; // lock byte was read
  logic code_resv_reg, code_resv_next; // reserved was read

  // merge masked bits into a register byte
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data, input logic [7:0] mask);
    merge = (old & ~mask) | (data & mask);
  endfunction : merge

  // =====================================================
  // data space decode
  // bank comes from the two status word bits
  assign bank = {i_program_status_word[mmap_pkg::BANK_HI_POS], i_program_status_word[mmap_pkg::BANK_LO_POS]};

  // pick effective address and target in the request cycle
  always_comb begin
    eff_addr = i_data_req.addr;
    bit_pos = i_data_req.addr[2:0];
    wmask = '1;
    wbyte = i_data_req.wdata;
    tgt = mmap_pkg::TGT_NONE;
    if (i_data_req.valid) begin
      case (i_data_req.mode)
        // bank register: four banks of eight bytes
        mmap_pkg::MODE_BANKREG: begin
          eff_addr = {3'h0, bank, i_data_req.addr[2:0]};
          tgt = mmap_pkg::TGT_IRAM;
        end
        // direct above lower half goes to registers
        mmap_pkg::MODE_DIRECT: begin
          if (i_data_req.addr > mmap_pkg::LOWER_TOP) begin
            tgt = mmap_pkg::TGT_SFR;
          end else begin
            tgt = mmap_pkg::TGT_IRAM;
          end
        end
        // indirect always reaches ram, upper half too
        mmap_pkg::MODE_INDIRECT: begin
          tgt = mmap_pkg::TGT_IRAM;
        end
        // bit access: low bits in ram, high in registers
        mmap_pkg::MODE_BIT: begin
          wmask = mmap_pkg::BIT_ONE << i_data_req.addr[2:0];
          wbyte = {8{i_data_req.wdata[0]}};
          if (i_data_req.addr[7]) begin
            eff_addr = {i_data_req.addr[7:3], 3'h0};
            tgt = mmap_pkg::TGT_SFR;
          end else begin
            eff_addr = mmap_pkg::BIT_BASE + {4'h0, i_data_req.addr[6:3]};
            tgt = mmap_pkg::TGT_IRAM;
          end
        end
        default: begin
          tgt = mmap_pkg::TGT_NONE;
        end
      endcase
    end
  end

  // stack ops own the ram port; data access yields
  assign stk_go = i_stack_req.push | i_stack_req.pop;
  assign data_go = i_data_req.valid & ~stk_go;
  // exactly one target is reported
  assign o_data_target = data_go ? tgt : mmap_pkg::TGT_NONE;

  // =====================================================
  // internal ram port
  // internal ram covers 0x00 to 0xFF, separate from registers
  always_comb begin
    iram_we = 1'b0;
    iram_re = 1'b0;
    iram_addr = eff_addr;
    iram_wdata = wbyte;
    iram_wmask = wmask;
    if (i_stack_req.push) begin
      // store at the incremented pointer
      iram_we = 1'b1;
      iram_addr = sp_reg + mmap_pkg::ONE_BYTE;
      iram_wdata = i_stack_req.wdata;
      iram_wmask = '1;
    end else if (i_stack_req.pop) begin
      // read the top before the decrement
      iram_re = 1'b1;
      iram_addr = sp_reg;
    end else if (data_go && tgt == mmap_pkg::TGT_IRAM) begin
      iram_we = i_data_req.write;
      iram_re = ~i_data_req.write;
    end
  end

  // lower 256 bytes of the 512 byte data ram
  ram_block #(
    .DEPTH(mmap_pkg::IRAM_DEPTH)
  ) u_iram (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_we(iram_we), .i_re(iram_re),
    .i_addr(iram_addr), .i_wdata(iram_wdata), .i_wmask(iram_wmask), .o_rdata(iram_q)
  );

  // =====================================================
  // special registers
  assign sfr_we = data_go && tgt == mmap_pkg::TGT_SFR && i_data_req.write;
  assign sfr_re = data_go && tgt == mmap_pkg::TGT_SFR && !i_data_req.write;
  // addresses not held here go to other peripherals
  assign o_sfr_other_sel = data_go && tgt == mmap_pkg::TGT_SFR && eff_addr != mmap_pkg::SFR_SP &&
                           eff_addr != mmap_pkg::SFR_ACC && eff_addr != mmap_pkg::SFR_B;

  // register read mux
  always_comb begin
    case (eff_addr)
      mmap_pkg::SFR_SP: sfr_rd = sp_reg;
      mmap_pkg::SFR_ACC: sfr_rd = acc_reg;
      mmap_pkg::SFR_B: sfr_rd = b_reg;
      default: sfr_rd = mmap_pkg::READ_NONE;
    endcase
  end

  // register next values; push or pop beats a write
  always_comb begin
    sp_next = sp_reg;
    acc_next = acc_reg;
    b_next = b_reg;
    if (i_stack_req.push) begin
      sp_next = sp_reg + mmap_pkg::ONE_BYTE;
    end else if (i_stack_req.pop) begin
      sp_next = sp_reg - mmap_pkg::ONE_BYTE;
    end else if (sfr_we && eff_addr == mmap_pkg::SFR_SP) begin
      sp_next = merge(sp_reg, wbyte, wmask);
    end
    if (sfr_we && eff_addr == mmap_pkg::SFR_ACC) begin
      acc_next = merge(acc_reg, wbyte, wmask);
    end
    if (sfr_we && eff_addr == mmap_pkg::SFR_B) begin
      b_next = merge(b_reg, wbyte, wmask);
    end
  end

  // register storage
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sp_reg <= mmap_pkg::SP_RESET;
      acc_reg <= mmap_pkg::ACC_RESET;
      b_reg <= mmap_pkg::B_RESET;
    end else begin
      sp_reg <= sp_next;
      acc_reg <= acc_next;
      b_reg <= b_next;
    end
  end
  assign o_stack_pointer = sp_reg;
  assign o_primary_arith_reg = acc_reg;
  assign o_second_arith_reg = b_reg;

  // =====================================================
  // on-chip external ram and flash redirect
  // ext address check against flash map
  flash_decode u_ext_dec (
    .i_size(i_flash_size), .i_addr(i_ext_req.addr),
    .o_in_flash(ext_in_flash), .o_is_lock(ext_is_lock), .o_reserved(ext_reserved)
  );

  // writes go to flash only when redirected
  assign ext_to_flash = i_ext_req.valid & i_ext_req.write & i_flash_wr_redirect;
  assign onchip_external_ram_we = i_ext_req.valid & i_ext_req.write & ~i_flash_wr_redirect;
  assign onchip_external_ram_re = i_ext_req.valid & ~i_ext_req.write;
  // reserved program space is not storage
  assign o_ext_refused = ext_to_flash & ext_reserved;

  // upper 256 bytes of the 512 byte data ram
  ram_block #(
    .DEPTH(mmap_pkg::ONCHIP_EXTERNAL_RAM_DEPTH)
  ) u_onchip_external_ram (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_we(onchip_external_ram_we), .i_re(onchip_external_ram_re),
    .i_addr(i_ext_req.addr[7:0]), .i_wdata(i_ext_req.wdata), .i_wmask('1), .o_rdata(onchip_external_ram_q)
  );

  // =====================================================
  // program space
  // code address check against flash map
  flash_decode u_code_dec (
    .i_size(i_flash_size), .i_addr(i_code_req.addr),
    .o_in_flash(code_in_flash), .o_is_lock(code_is_lock), .o_reserved(code_reserved)
  );

  // flash strobes; reads only from code fetch
  always_comb begin
    o_flash_cmd.rd = i_code_req.valid & code_in_flash;
    o_flash_cmd.raddr = i_code_req.addr;
    o_flash_cmd.wr = ext_to_flash & ext_in_flash & ~i_flash_erase_sel;
    o_flash_cmd.erase = ext_to_flash & ext_in_flash & i_flash_erase_sel;
    o_flash_cmd.waddr = i_ext_req.addr;
    o_flash_cmd.wdata = i_ext_req.wdata;
  end

  // code answer; reserved space reads as erased
  always_comb begin
    code_valid_next = i_code_req.valid;
    code_data_next = code_data_reg;
    code_lock_next = 1'b0;
    code_resv_next = 1'b0;
    if (i_code_req.valid) begin
      code_lock_next = code_is_lock;
      code_resv_next = code_reserved;
      if (code_in_flash) begin
        code_data_next = i_flash_rdata;
      end else begin
        code_data_next = mmap_pkg::FLASH_ERASED;
      end
    end
  end

  // code answer registers
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      code_valid_reg <= 1'b0;
      code_data_reg <= mmap_pkg::READ_NONE;
      code_lock_reg <= 1'b0;
      code_resv_reg <= 1'b0;
    end else begin
      code_valid_reg <= code_valid_next;
      code_data_reg <= code_data_next;
      code_lock_reg <= code_lock_next;
      code_resv_reg <= code_resv_next;
    end
  end
  assign o_code_valid = code_valid_reg;
  assign o_code_data = code_data_reg;
  assign o_code_lock = code_lock_reg;
  assign o_code_reserved = code_resv_reg;

  // =====================================================
  // read answers
  // note what the next cycle must return
  always_comb begin
    rd_valid_next = 1'b0;
    rd_tgt_next = rd_tgt_reg;
    rd_bit_next = rd_bit_reg;
    sfr_q_next = sfr_q_reg;
    x_valid_next = onchip_external_ram_re;
    if (i_stack_req.pop) begin
      rd_valid_next = 1'b1;
      rd_tgt_next = mmap_pkg::TGT_IRAM;
      rd_bit_next = 3'h0;
    end else if (data_go && !i_data_req.write) begin
      rd_valid_next = 1'b1;
      rd_tgt_next = tgt;
      rd_bit_next = bit_pos;
      if (sfr_re) begin
        sfr_q_next = sfr_rd;
      end
    end
  end

  // read answer registers
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_valid_reg <= 1'b0;
      rd_tgt_reg <= mmap_pkg::TGT_NONE;
      rd_bit_reg <= 3'h0;
      sfr_q_reg <= mmap_pkg::READ_NONE;
      x_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_valid_next;
      rd_tgt_reg <= rd_tgt_next;
      rd_bit_reg <= rd_bit_next;
      sfr_q_reg <= sfr_q_next;
      x_valid_reg <= x_valid_next;
    end
  end

  // select among latched sources
  always_comb begin
    case (rd_tgt_reg)
      mmap_pkg::TGT_IRAM: o_rdata = iram_q;
      mmap_pkg::TGT_SFR: o_rdata = sfr_q_reg;
      default: o_rdata = mmap_pkg::READ_NONE;
    endcase
  end

  assign o_rbit = o_rdata[rd_bit_reg];
  assign o_rdata_valid = rd_valid_reg;
  assign o_xdata_valid = x_valid_reg;
  assign o_xdata = onchip_external_ram_q;

endmodule : mcu_memory_map_decode

/* File: tb/flash_array_model.sv */
`timescale 1ns/1ps
// =====================================================
// flash array on the far side of the decode block
module flash_array_model (
  input wire logic i_sys_clk,
  input wire mmap_pkg::flash_cmd_t i_cmd,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [int]; // bytes written so far
  logic [7:0] last_reg = 8'h00; // last byte read from the array
  // stores redirected writes and erases
  always @(posedge i_sys_clk) begin
    if (i_cmd.erase) mem[int'(i_cmd.waddr)] = 8'hFF;
    else if (i_cmd.wr) mem[int'(i_cmd.waddr)] = i_cmd.wdata;
    if (i_cmd.rd) last_reg <= o_rdata;
  end
  // same-cycle read, otherwise the inverse of the last byte read
  always @(i_cmd or last_reg) begin
    if (i_cmd.rd) o_rdata = mem.exists(int'(i_cmd.raddr)) ? mem[int'(i_cmd.raddr)] : i_cmd.raddr[7:0] ^ 8'hA5;
    else o_rdata = ~last_reg;
  end
endmodule : flash_array_model

/* File: tb/mcu_memory_map_decode_sva.sv */
`timescale 1ns/1ps
// =====================================================
// port checker for the decode block
module mmap_decode_checker (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire mmap_pkg::flash_size_t i_flash_size,
  input wire logic i_flash_wr_redirect,
  input wire mmap_pkg::data_req_t i_data_req,
  input wire mmap_pkg::stack_req_t i_stack_req,
  input wire mmap_pkg::ext_req_t i_ext_req,
  input wire mmap_pkg::code_req_t i_code_req,
  input wire mmap_pkg::flash_cmd_t o_flash_cmd,
  input wire mmap_pkg::target_t o_data_target,
  input wire logic o_rdata_valid,
  input wire logic o_xdata_valid,
  input wire logic o_ext_refused,
  input wire logic o_code_valid,
  input wire logic [7:0] o_code_data,
  input wire logic o_code_lock,
  input wire logic o_code_reserved,
  input wire logic [7:0] o_stack_pointer
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  logic [15:0] top_w; // last flash address for the strap
  logic dq_w; // data request not hidden by a stack op
  // lock byte address per size
  always_comb begin
    case (i_flash_size)
      mmap_pkg::SIZE_8K: top_w = 16'h1FFF;
      mmap_pkg::SIZE_4K: top_w = 16'h0FFF;
      default: top_w = 16'h07FF;
    endcase
  end
  assign dq_w = i_data_req.valid && !i_stack_req.push && !i_stack_req.pop;
  a_push_incr: assert property (i_stack_req.push |=> o_stack_pointer == $past(o_stack_pointer) + 8'h01)
    else $error("stack pointer not raised by push");
  a_pop_decr: assert property (i_stack_req.pop |=> o_stack_pointer == $past(o_stack_pointer) - 8'h01)
    else $error("stack pointer not lowered by pop");
  a_read_answer: assert property (dq_w && !i_data_req.write |=> o_rdata_valid)
    else $error("data read not answered");
  a_direct_upper: assert property (
    dq_w && i_data_req.mode == mmap_pkg::MODE_DIRECT && i_data_req.addr > 8'h7F
    |-> o_data_target == mmap_pkg::TGT_SFR)
    else $error("direct upper access not sent to registers");
  a_indirect_ram: assert property (dq_w && i_data_req.mode == mmap_pkg::MODE_INDIRECT
    |-> o_data_target == mmap_pkg::TGT_IRAM)
    else $error("indirect access not sent to ram");
  a_flash_read: assert property (i_code_req.valid && i_code_req.addr <= top_w
    |-> o_flash_cmd.rd && o_flash_cmd.raddr == i_code_req.addr)
    else $error("flash read strobe wrong");
  a_lock_byte: assert property (i_code_req.valid && i_code_req.addr == top_w |=> o_code_valid && o_code_lock)
    else $error("lock byte not flagged");
  a_code_reserved: assert property (i_code_req.valid && i_code_req.addr > top_w
    |=> o_code_reserved && o_code_data == 8'hFF && !o_code_lock)
    else $error("reserved code read wrong");
  a_ext_refused: assert property (i_ext_req.valid && i_ext_req.write && i_flash_wr_redirect && i_ext_req.addr > top_w
    |-> o_ext_refused && !o_flash_cmd.wr && !o_flash_cmd.erase)
    else $error("reserved flash write not refused");
  a_xdata_answer: assert property (i_ext_req.valid && !i_ext_req.write ##1 1'b1 |-> o_xdata_valid)
    else $error("external read not answered");
endmodule : mmap_decode_checker

bind mcu_memory_map_decode mmap_decode_checker chk (.i_sys_clk, .i_arst_n, .i_flash_size, .i_flash_wr_redirect,
  .i_data_req, .i_stack_req, .i_ext_req, .i_code_req, .o_flash_cmd, .o_data_target, .o_rdata_valid,
  .o_xdata_valid, .o_ext_refused, .o_code_valid, .o_code_data, .o_code_lock, .o_code_reserved, .o_stack_pointer);

/* File: tb/mcu_memory_map_decode_bench.sv */
`timescale 1ns/1ps
// =====================================================
// self-checking bench for the memory map decode
module mcu_memory_map_decode_bench;
  logic sys_clk, arst_n, redirect, erase_sel, rvalid, rbit, xvalid, refused, cvalid, clock, cres, sother;
  logic ref_seen, strobe_seen, other_seen; // combinational answers in the request cycle
  logic [7:0] program_status_word, frdata, got, rdata, xdata, cdata, sp, acc, breg; // bytes at the ports
  logic [7:0] ra [3] = '{8'hE0, 8'hF0, 8'h81}; // register addresses
  logic [7:0] rv [3] = '{8'h3C, 8'h5A, 8'h20}; // register test values
  logic [15:0] tops [3] = '{16'h1FFF, 16'h0FFF, 16'h07FF}; // lock byte per size
  mmap_pkg::flash_size_t fsize;
  mmap_pkg::data_req_t dreq;
  mmap_pkg::stack_req_t sreq;
  mmap_pkg::ext_req_t xreq;
  mmap_pkg::code_req_t creq;
  mmap_pkg::flash_cmd_t fcmd;
  mmap_pkg::target_t tgt;
  int err_total, comparisons;

  mcu_memory_map_decode dut (.i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_flash_size(fsize),
    .i_program_status_word(program_status_word), .i_flash_wr_redirect(redirect), .i_flash_erase_sel(erase_sel),
    .i_data_req(dreq), .i_stack_req(sreq), .i_ext_req(xreq), .i_code_req(creq), .i_flash_rdata(frdata),
    .o_flash_cmd(fcmd), .o_data_target(tgt), .o_sfr_other_sel(sother), .o_rdata_valid(rvalid), .o_rdata(rdata),
    .o_rbit(rbit), .o_xdata_valid(xvalid), .o_xdata(xdata), .o_ext_refused(refused), .o_code_valid(cvalid),
    .o_code_data(cdata), .o_code_lock(clock), .o_code_reserved(cres), .o_stack_pointer(sp),
    .o_primary_arith_reg(acc), .o_second_arith_reg(breg));
  flash_array_model flash (.i_sys_clk(sys_clk), .i_cmd(fcmd), .o_rdata(frdata));

  // =====================================================
  // clock and helpers
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one data access, read byte left in got
  task data_op(input logic wr, input mmap_pkg::access_mode_t md, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    dreq <= '{1'b1, wr, md, a, d};
    #1 other_seen = sother;
    @(posedge sys_clk);
    dreq <= '0;
    #1 got = rdata;
    if (!wr) check({7'h00, rvalid}, 8'h01);
  endtask : data_op
  task stack_op(input logic pu, input logic po, input logic [7:0] d);
    @(posedge sys_clk);
    sreq <= '{pu, po, d};
    @(posedge sys_clk);
    sreq <= '0;
    #1 got = rdata;
  endtask : stack_op
  task ext_op(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    xreq <= '{1'b1, wr, a, d};
    #1 ref_seen = refused;
    strobe_seen = fcmd.wr | fcmd.erase;
    @(posedge sys_clk);
    xreq <= '0;
    #1 got = xdata;
    if (!wr) check({7'h00, xvalid}, 8'h01);
  endtask : ext_op
  task code_op(input logic [15:0] a);
    @(posedge sys_clk);
    creq <= '{1'b1, a};
    @(posedge sys_clk);
    creq <= '0;
    #1 got = cdata;
    check({7'h00, cvalid}, 8'h01);
  endtask : code_op
  task report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  // =====================================================
  // main sequence
  initial begin
    {arst_n, redirect, erase_sel, program_status_word, dreq, sreq, xreq, creq} = '0;
    fsize = mmap_pkg::SIZE_8K;
    repeat (5) @(posedge sys_clk);
    check(sp, 8'h07);
    check(acc, 8'h00);
    check(breg, 8'h00);
    arst_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      data_op(1'b1, mmap_pkg::MODE_DIRECT, ra[i], rv[i]);
      data_op(1'b0, mmap_pkg::MODE_DIRECT, ra[i], 8'h00);
      check(got, rv[i]);
    end
    data_op(1'b0, mmap_pkg::MODE_DIRECT, 8'h90, 8'h00);
    check(got, 8'h00);
    check({7'h00, other_seen}, 8'h01);
    data_op(1'b1, mmap_pkg::MODE_DIRECT, 8'h81, 8'h07);
    data_op(1'b1, mmap_pkg::MODE_INDIRECT, 8'hE0, 8'h99);
    data_op(1'b0, mmap_pkg::MODE_DIRECT, 8'hE0, 8'h00);
    check(got, 8'h3C);
    check({7'h00, other_seen}, 8'h00);
    data_op(1'b0, mmap_pkg::MODE_INDIRECT, 8'hE0, 8'h00);
    check(got, 8'h99);
    data_op(1'b1, mmap_pkg::MODE_DIRECT, 8'h45, 8'h11);
    data_op(1'b0, mmap_pkg::MODE_INDIRECT, 8'h45, 8'h00);
    check(got, 8'h11);
    for (int b = 0; b < 4; b++) begin
      @(posedge sys_clk);
      program_status_word <= 8'(b << 3);
      data_op(1'b1, mmap_pkg::MODE_BANKREG, 8'h01, 8'(8'h40 + b));
      data_op(1'b0, mmap_pkg::MODE_INDIRECT, 8'(8 * b + 1), 8'h00);
      check(got, 8'(8'h40 + b));
    end
    data_op(1'b1, mmap_pkg::MODE_INDIRECT, 8'h22, 8'h00);
    data_op(1'b1, mmap_pkg::MODE_BIT, 8'h13, 8'h01);
    data_op(1'b0, mmap_pkg::MODE_INDIRECT, 8'h22, 8'h00);
    check(got, 8'h08);
    data_op(1'b0, mmap_pkg::MODE_BIT, 8'h13, 8'h00);
    check({7'h00, rbit}, 8'h01);
    data_op(1'b1, mmap_pkg::MODE_BIT, 8'hE7, 8'h01);
    check(acc, 8'hBC);
    data_op(1'b0, mmap_pkg::MODE_BIT, 8'hF1, 8'h00);
    check({7'h00, rbit}, 8'h01);
    stack_op(1'b1, 1'b0, 8'h55);
    check(sp, 8'h08);
    data_op(1'b0, mmap_pkg::MODE_INDIRECT, 8'h08, 8'h00);
    check(got, 8'h55);
    stack_op(1'b0, 1'b1, 8'h00);
    check(got, 8'h55);
    check(sp, 8'h07);
    ext_op(1'b1, 16'h0011, 8'hAB);
    ext_op(1'b0, 16'h0011, 8'h00);
    check(got, 8'hAB);
    data_op(1'b0, mmap_pkg::MODE_INDIRECT, 8'h11, 8'h00);
    check(got, 8'h42);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      fsize <= mmap_pkg::flash_size_t'(i);
      code_op(tops[i]);
      check(got, tops[i][7:0] ^ 8'hA5);
      check({7'h00, clock}, 8'h01);
      code_op(tops[i] + 16'h0001);
      check({7'h00, cres}, 8'h01);
    end
    @(posedge sys_clk);
    fsize <= mmap_pkg::SIZE_8K;
    redirect <= 1'b1;
    ext_op(1'b1, 16'h0100, 8'h3E);
    check({7'h00, strobe_seen}, 8'h01);
    code_op(16'h0100);
    check(got, 8'h3E);
    @(posedge sys_clk);
    erase_sel <= 1'b1;
    ext_op(1'b1, 16'h0100, 8'h00);
    code_op(16'h0100);
    check(got, 8'hFF);
    ext_op(1'b1, 16'h2000, 8'h00);
    check({6'h00, ref_seen, strobe_seen}, 8'h02);
    report_and_stop();
  end

  // watchdog well beyond the sequence length
  initial begin
    #300000;
    err_total++;
    report_and_stop();
  end
endmodule : mcu_memory_map_decode_bench
